// ---- ccd_defines.svh ----
// Purpose: Offsets, field positions, reset values and write masks of the
//          clock source and divider control block.
// Assumes: Byte addresses on a 32-bit Avalon-MM register bus.
// Notes:   Definitions only.
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

`define CCD_ADDR_W 6
`define CCD_OFS_OSC 6'h00
`define CCD_OFS_TRIM 6'h04
`define CCD_OFS_CR2 6'h08
`define CCD_OFS_CR3 6'h0C
`define CCD_OFS_CR4 6'h10
`define CCD_OFS_CR5 6'h14
`define CCD_OFS_CR6 6'h20
`define CCD_OFS_CR7 6'h24
`define CCD_OFS_CR8 6'h28

`define CCD_RST_OSC 8'h09
`define CCD_RST_TRIM 7'h40
`define CCD_RST_CR 32'h0000_0000

`define CCD_WM_CR2 32'h00FF_00FF
`define CCD_WM_CR3 32'h0000_007F
`define CCD_WM_CR4 32'h00F7_007F
`define CCD_WM_CR5 32'h0003_00F0
`define CCD_WM_CR6 32'h00F7_0007
`define CCD_WM_CR7 32'h00FF_00FF

`define CCD_OSC_SLOW_SEL 6
`define CCD_OSC_FAST_SEL 5
`define CCD_OSC_FREQ_LSB 3
`define CCD_OSC_XS_EN 2
`define CCD_OSC_XF_EN 1
`define CCD_OSC_RF_EN 0
`define CCD_OSC_XF_HS 7

`define CCD_CR2_RTC_LSB 22
`define CCD_CR2_U1_SRC 21
`define CCD_CR2_PRE_LSB 19
`define CCD_CR2_U1_DIV_LSB 16
`define CCD_CR2_TBC_SRC_LSB 6
`define CCD_CR2_TBC_DIV_LSB 4
`define CCD_CR2_TA_SRC_LSB 2
`define CCD_CR2_U1_GATE 1
`define CCD_CR2_CPU_SEL 0
`define CCD_CR3_ADC_LSB 4
`define CCD_CR3_SPI_GATE 3
`define CCD_CR3_SPI_DIV_LSB 0
`define CCD_CR4_PUMP_LSB 22
`define CCD_CR4_U2_SRC 21
`define CCD_CR4_U2_GATE 20
`define CCD_CR4_U2_DIV_LSB 16
`define CCD_CR4_LCD2_LSB 4
`define CCD_CR4_LCD1_LSB 1
`define CCD_CR4_LCD_SRC 0
`define CCD_CR5_SPI_SRC 17
`define CCD_CR5_TWI_SRC 16
`define CCD_CR5_TB2_SRC_LSB 6
`define CCD_CR5_TB2_DIV_LSB 4

`define CCD_DIV_TIMER_A 12'h020
`define CCD_DIV_LCD_SLOW 12'h008
`define CCD_DIV_LCD_FAST 12'h040
`define CCD_DIV_PUMP_FAST 12'h008

`endif

// ---- ccd_pkg.sv ----
// Purpose: Types shared by the clock source and divider control block.
// Assumes: Oscillator inputs are sampled square waves synchronous to REF_CLK.
// Notes:   Clock outputs are one-cycle ticks, one per divided clock rising edge.
package ccd_pkg;

	typedef struct packed {
		logic rc_slow;
		logic rc_fast;
		logic xtal_slow;
		logic xtal_fast;
	} ccd_osc_in_t;

	typedef struct packed {
		logic xtal_slow_en;
		logic xtal_fast_en;
		logic rc_fast_en;
		logic [1:0] rc_fast_freq_sel;
		logic [6:0] rc_fast_trim;
		logic xtal_fast_high;
	} ccd_osc_ctl_t;

	typedef struct packed {
		logic fast;
		logic slow;
		logic cpu;
		logic timer_a;
		logic timer_bc;
		logic timer_b2nd;
		logic rtc;
		logic uart1;
		logic uart2nd;
		logic spi;
		logic twowire;
		logic adc;
		logic lcd;
		logic pump;
	} ccd_ticks_t;

	typedef enum logic [1:0] {
		CCD_SRC_OFF = 2'h0,
		CCD_SRC_FAST = 2'h1,
		CCD_SRC_ALT = 2'h2,
		CCD_SRC_SLOW = 2'h3
	} ccd_tmr_src_t;

endpackage : ccd_pkg

// ---- ccd_clock_ctrl.sv ----
// Purpose: Clock source selection, oscillator enables and clock dividers.
// Assumes: Avalon-MM slave with waitrequest; one wait cycle per access.
// Notes:   Derived clocks leave as one-cycle ticks from divider flip-flops.
//
// Operation
// - bit 6 picks slow RC or slow crystal.
// - bit 5 picks fast RC or fast crystal.
// - two-bit fast RC frequency code, default 01.
// - bits 2..0 enable the three oscillators.
// - source switch refused if target oscillator off.
// - both fast oscillators off only on slow CPU.
// - seven-bit fast RC trim, default 100_0000.
// - RTC off, slow crystal if enabled, or slow RC.
// - primary UART from fast RC, gated, power-two divide.
// - CPU prescale by 2, 4, 8 or 1.
// - timer B/C source select then divide 1..8.
// - timer A source select then fixed divide 32.
// - ADC clock off or fast clock divided 2..128.
// - SPI gate and divide 1 up to 2048.
// - charge pump clock from slow or fast path.
// - second UART from fast RC, gated, divided.
// - LCD first stage off, or divide 1..32.
// - LCD second stage divides by odd 2n+1.
// - SPI and two-wire sources: crystal or RC.
// - timer B2 source select then divide 1..8.
// - CPU path fed from fast or slow clock.
`timescale 1ns/100ps

`include "ccd_defines.svh"

module ccd_clock_ctrl
(
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic [`CCD_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire ccd_pkg::ccd_osc_in_t OSC_IN,
	output ccd_pkg::ccd_osc_ctl_t OSC_CTL,
	output ccd_pkg::ccd_ticks_t TICKS
);

	localparam int NCR = 6;
	localparam int NDIV = 14;
	localparam int DIV_W = 12;

	logic wait_r;
	logic [31:0] rdata_r;
	logic [7:0] osc_r;
	logic [6:0] trim_r;
	logic [31:0] ctl_r [0:NCR-1];
	logic [3:0] osc_d_r;
	logic req;
	logic acc_wr;
	logic [7:0] osc_m;
	logic [7:0] osc_cand;
	logic [7:0] osc_nxt;
	logic [31:0] cr_m;
	logic [31:0] cr2;
	logic [31:0] cr3;
	logic [31:0] cr4;
	logic [31:0] cr5;
	logic t_rs;
	logic t_rf;
	logic t_xs;
	logic t_xf;
	logic t_fast;
	logic t_slow;
	logic t_alt;
	logic [NDIV-1:0] d_src;
	logic [NDIV-1:0] d_en;
	logic [DIV_W-1:0] d_ratio [0:NDIV-1];
	logic [NDIV-1:0] d_out_r;

	function automatic logic [`CCD_ADDR_W-1:0] cr_ofs(input int i);
		case (i)
			0: cr_ofs = `CCD_OFS_CR2;
			1: cr_ofs = `CCD_OFS_CR3;
			2: cr_ofs = `CCD_OFS_CR4;
			3: cr_ofs = `CCD_OFS_CR5;
			4: cr_ofs = `CCD_OFS_CR6;
			default: cr_ofs = `CCD_OFS_CR7;
		endcase
	endfunction : cr_ofs

	function automatic logic [31:0] cr_wm(input int i);
		case (i)
			0: cr_wm = `CCD_WM_CR2;
			1: cr_wm = `CCD_WM_CR3;
			2: cr_wm = `CCD_WM_CR4;
			3: cr_wm = `CCD_WM_CR5;
			4: cr_wm = `CCD_WM_CR6;
			default: cr_wm = `CCD_WM_CR7;
		endcase
	endfunction : cr_wm

	function automatic logic [DIV_W-1:0] pow2(input logic [3:0] n);
		pow2 = DIV_W'(12'h001 << n);
	endfunction : pow2

	function automatic logic tmr_pick(input logic [1:0] code,
		input logic f, input logic a, input logic s);
		case (ccd_pkg::ccd_tmr_src_t'(code))
			ccd_pkg::CCD_SRC_FAST: tmr_pick = f;
			ccd_pkg::CCD_SRC_ALT: tmr_pick = a;
			ccd_pkg::CCD_SRC_SLOW: tmr_pick = s;
			default: tmr_pick = 1'b0;
		endcase
	endfunction : tmr_pick

	assign req = AVS_READ | AVS_WRITE;
	assign acc_wr = AVS_WRITE & ~wait_r;
	assign cr2 = ctl_r[0];
	assign cr3 = ctl_r[1];
	assign cr4 = ctl_r[2];
	assign cr5 = ctl_r[3];

	// Each access waits one cycle; the request is taken when wait drops.
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			wait_r <= 1'b1;
		else
			wait_r <= ~(req & wait_r);
	end

	// Read data is loaded in the waiting cycle and stands when wait drops.
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			rdata_r <= 32'h0000_0000;
		else if (AVS_READ & wait_r)
		begin
			case (AVS_ADDRESS)
				`CCD_OFS_OSC: rdata_r <= {24'h00_0000, osc_r};
				`CCD_OFS_TRIM: rdata_r <= {25'h000_0000, trim_r};
				`CCD_OFS_CR2: rdata_r <= ctl_r[0];
				`CCD_OFS_CR3: rdata_r <= ctl_r[1];
				`CCD_OFS_CR4: rdata_r <= ctl_r[2];
				`CCD_OFS_CR5: rdata_r <= ctl_r[3];
				`CCD_OFS_CR6: rdata_r <= ctl_r[4];
				`CCD_OFS_CR7: rdata_r <= ctl_r[5];
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Oscillator control byte with its safety checks.
	always_comb
	begin
		osc_m = (AVS_BYTEENABLE[1] & AVS_BYTEENABLE[0]) ?
			AVS_WRITEDATA[15:8] : 8'h00;
		osc_cand = (osc_r & ~osc_m) | (AVS_WRITEDATA[7:0] & osc_m);
		osc_nxt = osc_cand;
		if (!osc_cand[`CCD_OSC_XF_EN] && !osc_cand[`CCD_OSC_RF_EN] &&
			!cr2[`CCD_CR2_CPU_SEL])
		begin
			osc_nxt[`CCD_OSC_XF_EN] = osc_r[`CCD_OSC_XF_EN];
			osc_nxt[`CCD_OSC_RF_EN] = osc_r[`CCD_OSC_RF_EN];
		end
		if (osc_cand[`CCD_OSC_FAST_SEL] != osc_r[`CCD_OSC_FAST_SEL])
		begin
			if (osc_cand[`CCD_OSC_FAST_SEL] ? !osc_nxt[`CCD_OSC_XF_EN] :
				!osc_nxt[`CCD_OSC_RF_EN])
				osc_nxt[`CCD_OSC_FAST_SEL] = osc_r[`CCD_OSC_FAST_SEL];
		end
		if (osc_cand[`CCD_OSC_SLOW_SEL] && !osc_r[`CCD_OSC_SLOW_SEL] &&
			!osc_nxt[`CCD_OSC_XS_EN])
			osc_nxt[`CCD_OSC_SLOW_SEL] = 1'b0;
	end

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			osc_r <= `CCD_RST_OSC;
		else if (acc_wr && AVS_ADDRESS == `CCD_OFS_OSC)
			osc_r <= osc_nxt;
	end

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			trim_r <= `CCD_RST_TRIM;
		else if (acc_wr && AVS_ADDRESS == `CCD_OFS_TRIM && AVS_BYTEENABLE[0])
			trim_r <= AVS_WRITEDATA[6:0];
	end

	assign cr_m = {8'h00,
		(AVS_BYTEENABLE[3] & AVS_BYTEENABLE[2]) ? AVS_WRITEDATA[31:24] : 8'h00,
		8'h00,
		(AVS_BYTEENABLE[1] & AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[15:8] : 8'h00};

	// Masked control registers; only writable bits are ever stored.
	genvar gi;
	generate
		for (gi = 0; gi < NCR; gi++)
		begin : g_cr
			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					ctl_r[gi] <= `CCD_RST_CR;
				else if (acc_wr && AVS_ADDRESS == cr_ofs(gi))
					ctl_r[gi] <= ((ctl_r[gi] & ~cr_m) |
						(AVS_WRITEDATA & cr_m)) & cr_wm(gi);
			end
		end
	endgenerate

	// Rising edges of the sampled oscillators, blocked while stopped.
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			osc_d_r <= 4'h0;
		else
			osc_d_r <= OSC_IN;
	end

	assign t_rs = OSC_IN.rc_slow & ~osc_d_r[3];
	assign t_rf = OSC_IN.rc_fast & ~osc_d_r[2] & osc_r[`CCD_OSC_RF_EN];
	assign t_xs = OSC_IN.xtal_slow & ~osc_d_r[1] & osc_r[`CCD_OSC_XS_EN];
	assign t_xf = OSC_IN.xtal_fast & ~osc_d_r[0] & osc_r[`CCD_OSC_XF_EN];
	assign t_slow = osc_r[`CCD_OSC_SLOW_SEL] ? t_xs : t_rs;
	assign t_fast = osc_r[`CCD_OSC_FAST_SEL] ? t_xf : t_rf;
	assign t_alt = osc_r[`CCD_OSC_FAST_SEL] ? t_rf : t_xf;

	// Source, enable and ratio of each divider channel.
	always_comb
	begin
		d_src = '0;
		d_en = '1;
		for (int k = 0; k < NDIV; k++)
			d_ratio[k] = 12'h001;
		d_src[0] = t_fast;
		d_src[1] = t_slow;
		d_src[2] = cr2[`CCD_CR2_CPU_SEL] ? t_slow : t_fast;
		case (cr2[`CCD_CR2_PRE_LSB +: 2])
			2'h0: d_ratio[2] = 12'h002;
			2'h1: d_ratio[2] = 12'h004;
			2'h2: d_ratio[2] = 12'h008;
			default: d_ratio[2] = 12'h001;
		endcase
		d_src[3] = tmr_pick(cr2[`CCD_CR2_TA_SRC_LSB +: 2], t_fast, t_alt,
			t_slow);
		d_ratio[3] = `CCD_DIV_TIMER_A;
		d_src[4] = tmr_pick(cr2[`CCD_CR2_TBC_SRC_LSB +: 2], t_fast, t_alt,
			t_slow);
		d_ratio[4] = pow2({2'h0, cr2[`CCD_CR2_TBC_DIV_LSB +: 2]});
		d_src[5] = tmr_pick(cr5[`CCD_CR5_TB2_SRC_LSB +: 2], t_fast, t_alt,
			t_slow);
		d_ratio[5] = pow2({2'h0, cr5[`CCD_CR5_TB2_DIV_LSB +: 2]});
		case (cr2[`CCD_CR2_RTC_LSB +: 2])
			2'h2: d_src[6] = t_xs;
			2'h3: d_src[6] = t_rs;
			default: d_src[6] = 1'b0;
		endcase
		d_src[7] = t_rf;
		d_en[7] = cr2[`CCD_CR2_U1_SRC] & cr2[`CCD_CR2_U1_GATE];
		d_ratio[7] = pow2({1'b0, cr2[`CCD_CR2_U1_DIV_LSB +: 3]});
		d_src[8] = t_rf;
		d_en[8] = cr4[`CCD_CR4_U2_SRC] & cr4[`CCD_CR4_U2_GATE];
		d_ratio[8] = pow2({1'b0, cr4[`CCD_CR4_U2_DIV_LSB +: 3]});
		d_src[9] = cr5[`CCD_CR5_SPI_SRC] ? t_rf : t_xf;
		d_en[9] = cr3[`CCD_CR3_SPI_GATE];
		case (cr3[`CCD_CR3_SPI_DIV_LSB +: 3])
			3'h4: d_ratio[9] = 12'h020;
			3'h5: d_ratio[9] = 12'h080;
			3'h6: d_ratio[9] = 12'h200;
			3'h7: d_ratio[9] = 12'h800;
			default: d_ratio[9] = pow2({1'b0, cr3[`CCD_CR3_SPI_DIV_LSB +: 3]});
		endcase
		d_src[10] = cr5[`CCD_CR5_TWI_SRC] ? t_rf : t_xf;
		d_src[11] = t_fast;
		d_en[11] = cr3[`CCD_CR3_ADC_LSB +: 3] != 3'h0;
		d_ratio[11] = pow2({1'b0, cr3[`CCD_CR3_ADC_LSB +: 3]});
		// Channel 12 is the fixed LCD source divider, 13 the first stage.
		d_src[12] = cr4[`CCD_CR4_LCD_SRC] ? t_fast : t_slow;
		d_ratio[12] = cr4[`CCD_CR4_LCD_SRC] ? `CCD_DIV_LCD_FAST :
			`CCD_DIV_LCD_SLOW;
		d_src[13] = d_out_r[12];
		d_en[13] = cr4[`CCD_CR4_LCD1_LSB +: 3] != 3'h0 &&
			cr4[`CCD_CR4_LCD1_LSB +: 3] != 3'h7;
		d_ratio[13] = pow2({1'b0, cr4[`CCD_CR4_LCD1_LSB +: 3] - 3'h1});
	end

	// Power-of-two and fixed ratio dividers, one per channel.
	generate
		for (gi = 0; gi < NDIV; gi++)
		begin : g_div
			logic [DIV_W-1:0] cnt_r;
			logic hit;
			assign hit = d_src[gi] && cnt_r >= d_ratio[gi] - 12'h001;
			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
				begin
					cnt_r <= '0;
					d_out_r[gi] <= 1'b0;
				end
				else
				begin
					d_out_r[gi] <= d_en[gi] & hit;
					if (!d_en[gi] || hit)
						cnt_r <= '0;
					else if (d_src[gi])
						cnt_r <= cnt_r + 12'h001;
				end
			end
		end
	endgenerate

	// LCD second stage and charge pump run on their own counters.
	logic [3:0] lcd2_cnt_r;
	logic [3:0] lcd2_top;
	logic lcd_r;
	logic [5:0] pump_cnt_r;
	logic [5:0] pump_top;
	logic pump_src;
	logic pump_r;
	logic [1:0] pump_code;

	assign lcd2_top = {cr4[`CCD_CR4_LCD2_LSB +: 3], 1'b0};
	assign pump_code = cr4[`CCD_CR4_PUMP_LSB +: 2] == 2'h3 ? 2'h2 :
		cr4[`CCD_CR4_PUMP_LSB +: 2];
	assign pump_src = cr4[`CCD_CR4_LCD_SRC] ? t_fast : t_slow;
	assign pump_top = cr4[`CCD_CR4_LCD_SRC] ?
		6'((`CCD_DIV_PUMP_FAST << pump_code) - 12'h001) :
		6'((12'h001 << pump_code) - 12'h001);

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			lcd2_cnt_r <= 4'h0;
			lcd_r <= 1'b0;
		end
		else
		begin
			lcd_r <= d_out_r[13] && lcd2_cnt_r >= lcd2_top;
			if (!d_en[13])
				lcd2_cnt_r <= 4'h0;
			else if (d_out_r[13])
				lcd2_cnt_r <= lcd2_cnt_r >= lcd2_top ? 4'h0 :
					lcd2_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			pump_cnt_r <= 6'h00;
			pump_r <= 1'b0;
		end
		else
		begin
			pump_r <= pump_src && pump_cnt_r >= pump_top;
			if (pump_src)
				pump_cnt_r <= pump_cnt_r >= pump_top ? 6'h00 :
					pump_cnt_r + 6'h01;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			OSC_CTL <= '0;
		else
		begin
			OSC_CTL.xtal_slow_en <= osc_r[`CCD_OSC_XS_EN];
			OSC_CTL.xtal_fast_en <= osc_r[`CCD_OSC_XF_EN];
			OSC_CTL.rc_fast_en <= osc_r[`CCD_OSC_RF_EN];
			OSC_CTL.rc_fast_freq_sel <= osc_r[`CCD_OSC_FREQ_LSB +: 2];
			OSC_CTL.rc_fast_trim <= trim_r;
			OSC_CTL.xtal_fast_high <= osc_r[`CCD_OSC_XF_HS];
		end
	end

	assign AVS_READDATA = rdata_r;
	assign AVS_WAITREQUEST = wait_r;
	assign TICKS = {d_out_r[0], d_out_r[1], d_out_r[2], d_out_r[3],
		d_out_r[4], d_out_r[5], d_out_r[6], d_out_r[7], d_out_r[8],
		d_out_r[9], d_out_r[10], d_out_r[11], lcd_r, pump_r};

endmodule : ccd_clock_ctrl

// ---- ccd_clock_ctrl_asserts.sv ----
// Purpose: Port checks for the clock control block.
// Assumes: One clock domain, reset active low.
// Notes: Bound to every instance of the block.
`timescale 1ns/100ps
`include "ccd_defines.svh"
module ccd_chk
(
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic [`CCD_ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire ccd_pkg::ccd_osc_in_t OSC_IN,
	input wire ccd_pkg::ccd_osc_ctl_t OSC_CTL,
	input wire ccd_pkg::ccd_ticks_t TICKS
);
	logic [7:0] ta_gap_r;
	logic req;
	logic rd_ack;
	assign req = AVS_READ | AVS_WRITE;
	assign rd_ack = AVS_READ & ~AVS_WAITREQUEST;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);
	always_ff @(posedge REF_CLK or negedge RESET_N)
	if (!RESET_N)
		ta_gap_r <= 8'h00;
	else if (TICKS.timer_a)
		ta_gap_r <= 8'h00;
	else if (ta_gap_r != 8'hFF)
		ta_gap_r <= ta_gap_r + 8'h01;
	sequence s_ack;
		!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence
	chk_bus_answer: assert property (req && AVS_WAITREQUEST |=> s_ack)
		else $error("request not answered after one wait cycle");
	chk_bus_idle: assert property (!req |=> AVS_WAITREQUEST)
		else $error("wait released without request");
	chk_unmapped_read: assert property (rd_ack && AVS_ADDRESS == 6'h18
		|-> AVS_READDATA == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_mask_zero: assert property (rd_ack && AVS_ADDRESS == 6'h00
		|-> AVS_READDATA[31:8] == 24'h00_0000)
		else $error("mask byte reads nonzero");
	chk_trim_read: assert property (rd_ack && AVS_ADDRESS == 6'h04
		|-> AVS_READDATA[31:7] == 25'h000_0000)
		else $error("trim upper bits nonzero");
	chk_reset_ctl: assert property ($rose(RESET_N) |=>
		OSC_CTL.rc_fast_en && OSC_CTL.rc_fast_freq_sel == 2'h1
		&& OSC_CTL.rc_fast_trim == 7'h40 && !OSC_CTL.xtal_fast_en)
		else $error("oscillator controls wrong after reset");
	chk_timer_a_gap: assert property (TICKS.timer_a |-> ta_gap_r >= 8'h7E)
		else $error("timer A tick too early");
	chk_fast_pulse: assert property (TICKS.fast |=> !TICKS.fast)
		else $error("fast tick wider than one cycle");
	chk_adc_gap: assert property (TICKS.adc |=> !TICKS.adc [*3])
		else $error("adc ticks too close");
endmodule : ccd_chk
bind ccd_clock_ctrl ccd_chk u_chk (.REF_CLK, .RESET_N, .AVS_ADDRESS,
	.AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
	.AVS_READDATA, .AVS_WAITREQUEST, .OSC_IN, .OSC_CTL, .TICKS);

// ---- ccd_osc_model.sv ----
// Purpose: Oscillator sources that feed the clock control block.
// Assumes: Half periods in REF_CLK cycles; slow RC always runs.
// Notes: A stopped oscillator holds its line low.
`timescale 1ns/100ps
module ccd_osc_model
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire ccd_pkg::ccd_osc_ctl_t ctl,
	output ccd_pkg::ccd_osc_in_t osc
);
	localparam logic [4:0] HALF [4] = '{5'h02, 5'h18, 5'h01, 5'h13};
	logic [4:0] cnt_r [4];
	logic [3:0] run;
	assign run = {1'b1, ctl.rc_fast_en, ctl.xtal_slow_en, ctl.xtal_fast_en};
	always_ff @(posedge ref_clk or negedge reset_n)
	if (!reset_n)
	begin
		osc <= '0;
		cnt_r <= '{default: 5'h00};
	end
	else
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (!run[i])
			begin
				osc[i] <= 1'b0;
				cnt_r[i] <= 5'h00;
			end
			else if (cnt_r[i] == HALF[i])
			begin
				osc[i] <= ~osc[i];
				cnt_r[i] <= 5'h00;
			end
			else
				cnt_r[i] <= cnt_r[i] + 5'h01;
		end
	end
endmodule : ccd_osc_model

// ---- ccd_clock_ctrl_tb.sv ----
// Purpose: Register and clock ratio tests of the clock control block.
// Assumes: One wait cycle per bus access.
// Notes: Oscillators come from the partner model.
`timescale 1ns/100ps
`include "ccd_defines.svh"
module ccd_clock_ctrl_tb;
	logic REF_CLK;
	logic RESET_N;
	logic [`CCD_ADDR_W-1:0] AVS_ADDRESS;
	logic AVS_READ;
	logic AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [3:0] AVS_BYTEENABLE;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	ccd_pkg::ccd_osc_in_t OSC_IN;
	ccd_pkg::ccd_osc_ctl_t OSC_CTL;
	ccd_pkg::ccd_ticks_t TICKS;
	int compares;
	int failures;
	int cycles;
	logic [5:0] addr_tbl [7];
	logic [31:0] exp_tbl [7];
	ccd_clock_ctrl u_ccd_clock_ctrl (.REF_CLK, .RESET_N, .AVS_ADDRESS,
		.AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
		.AVS_READDATA, .AVS_WAITREQUEST, .OSC_IN, .OSC_CTL, .TICKS);
	ccd_osc_model u_ccd_osc_model (.ref_clk(REF_CLK), .reset_n(RESET_N),
		.ctl(OSC_CTL), .osc(OSC_IN));
	always #2.5 REF_CLK = ~REF_CLK;
	task print_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= d;
		@(posedge REF_CLK);
		while (AVS_WAITREQUEST !== 1'b0)
			@(posedge REF_CLK);
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge REF_CLK);
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask : rdc
	task automatic osc(input logic [31:0] d, input logic [31:0] e);
		wr(`CCD_OFS_OSC, d);
		rdc(`CCD_OFS_OSC, e);
	endtask : osc
	task automatic ratio(input int y, input int x, input logic [31:0] e);
		logic [31:0] n;
		n = 32'h0000_0000;
		@(posedge REF_CLK iff TICKS[y] === 1'b1);
		do
		begin
			@(posedge REF_CLK);
			if (TICKS[x] === 1'b1)
				n++;
		end
		while (TICKS[y] !== 1'b1);
		chk(n, e);
	endtask : ratio
	always @(posedge REF_CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			print_verdict();
		end
	end
	initial
	begin
		REF_CLK = 1'b0;
		RESET_N = 1'b0;
		AVS_ADDRESS = '0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = '0;
		AVS_BYTEENABLE = 4'hF;
		compares = 0;
		failures = 0;
		cycles = 0;
		addr_tbl = '{6'h0C, 6'h10, 6'h14, 6'h20, 6'h24, 6'h28, 6'h18};
		exp_tbl = '{32'h0000_007F, 32'h00F7_007F, 32'h0003_00F0,
			`CCD_WM_CR6, `CCD_WM_CR7, 32'h0000_0000, 32'h0000_0000};
		repeat (10) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		@(posedge REF_CLK);
		rdc(`CCD_OFS_OSC, 32'h0000_0009);
		rdc(`CCD_OFS_TRIM, 32'h0000_0040);
		rdc(`CCD_OFS_CR2, 32'h0000_0000);
		osc(32'h0000_00FF, 32'h0000_0009);
		osc(32'h0000_2020, 32'h0000_0009);
		osc(32'h0000_2222, 32'h0000_002B);
		osc(32'h0000_4040, 32'h0000_002B);
		osc(32'h0000_4444, 32'h0000_006F);
		osc(32'h0000_2000, 32'h0000_004F);
		osc(32'h0000_0300, 32'h0000_004F);
		wr(`CCD_OFS_TRIM, 32'hFFFF_FFFF);
		rdc(`CCD_OFS_TRIM, 32'h0000_007F);
		AVS_BYTEENABLE <= 4'hE;
		wr(`CCD_OFS_TRIM, 32'h0000_0000);
		rdc(`CCD_OFS_TRIM, 32'h0000_007F);
		AVS_BYTEENABLE <= 4'h1;
		osc(32'h0000_FF00, 32'h0000_004F);
		AVS_BYTEENABLE <= 4'hF;
		wr(`CCD_OFS_CR2, 32'h0000_0D05);
		rdc(`CCD_OFS_CR2, 32'h0000_0005);
		ratio(10, 13, 32'h0000_0020);
		ratio(11, 12, 32'h0000_0002);
		for (int i = 0; i < 7; i++)
		begin
			wr(addr_tbl[i], 32'hFFFF_FFFF);
			rdc(addr_tbl[i], exp_tbl[i]);
		end
		ratio(2, 13, 32'h0000_0080);
		ratio(0, 13, 32'h0000_0020);
		ratio(5, 13, 32'h0000_0080);
		ratio(8, 12, 32'h0000_0008);
		ratio(13, 3, 32'h0000_0001);
		wr(`CCD_OFS_CR4, 32'h0000_7F13);
		ratio(1, 13, 32'h0000_00C0);
		wr(`CCD_OFS_CR2, 32'h2721_0202);
		ratio(6, 13, 32'h0000_0002);
		osc(32'h0000_0300, 32'h0000_004C);
		print_verdict();
	end
endmodule : ccd_clock_ctrl_tb
